// >>> inc/i2c_master_pkg.sv
// Shared register map, field positions, reset values and carrier types of the I2C master.
package i2c_master_pkg;

   // Word index of each register; the byte address is four times the index.
   localparam logic [2:0] IDX_CTRL   = 3'h0;
   localparam logic [2:0] IDX_STATUS = 3'h1;
   localparam logic [2:0] IDX_DIV    = 3'h2;
   localparam logic [2:0] IDX_BUF    = 3'h3;
   localparam logic [2:0] IDX_FLAGS  = 3'h4;

   // Field positions in the control-two register.
   localparam int CTRL_START_BIT   = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam int CTRL_STOP_BIT    = 2;
   localparam int CTRL_RXEN_BIT    = 3;
   localparam int CTRL_ACKDATA_BIT = 5;
   localparam int CTRL_ACKSTAT_BIT = 6;

   // Field positions in the port status register.
   localparam int STAT_BUFFULL_BIT = 0;
   localparam int STAT_START_BIT   = 3;
   localparam int STAT_STOP_BIT    = 4;

   // Reset values, and the last bit slot of a byte.
   localparam logic [6:0] DIV_RST     = 7'h3F;
   localparam logic [7:0] BUF_RST     = 8'h00;
   localparam logic [3:0] LAST_BIT    = 4'h8;

   // Sticky event flags; pirq sits in bit 0 of the flag register.
   typedef struct packed {
      logic write_collision_flag;
      logic coll;
      logic pirq;
   } flags_t;

   localparam flags_t FLAGS_RST = '{write_collision_flag: 1'b0, coll: 1'b0, pirq: 1'b0};

endpackage

// >>> verif/i2c_bus_partner.sv
// Far side of the I2C lines: pull-ups, a stretching slave and a jamming master.
`timescale 1ns/100ps
module i2c_bus_partner (
   input  wire logic       scl_oe_n_i,
   input  wire logic       sda_oe_n_i,
   input  wire logic       stretch_i,
   input  wire logic       jam_i,
   output logic            scl_o,
   output logic            sda_o,
   output logic      [8:0] bits_o
);
   // clock stretch
   // Pull-ups win unless someone pulls low; a slow slave holds SCL low.
   assign scl_o = scl_oe_n_i & ~stretch_i;
   // foreign master
   // A jam models another master already holding SDA low.
   assign sda_o = sda_oe_n_i & ~jam_i;
   // bits on wire
   // A listener samples SDA on every SCL rise; the last nine hold a byte and its ack slot.
   always_ff @(posedge scl_o) begin
      bits_o <= {bits_o[7:0], sda_o};
   end
endmodule

// >>> verif/tb.sv
// Self-checking bench for the I2C master sequencer.
`timescale 1ns/100ps
module tb;
   logic        clk, arst_n, rd_i, wr_i, stretch, jam, wait_o;
   logic        scl_oe_n, sda_oe_n, scl, sda;
   logic [2:0]  addr;
   logic [31:0] wdata, rdata, rd;
   logic [8:0]  seen;
   int          miscompares, checks;
   logic [2:0]  row_a [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
   logic [31:0] row_e [6] = '{32'h0, 32'h0, 32'h3F, 32'h0, 32'h0, 32'h0};
   i2c_master_start_restart_brg uut (.clk_sys_i(clk), .arst_n_i(arst_n),
      .address_i(addr), .read_i(rd_i), .write_i(wr_i), .writedata_i(wdata),
      .readdata_o(rdata), .waitrequest_o(wait_o), .scl_i(scl), .scl_o(),
      .scl_oe_n_o(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n_o(sda_oe_n));
   i2c_bus_partner far (.scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n),
      .stretch_i(stretch), .jam_i(jam), .scl_o(scl), .sda_o(sda),
      .bits_o(seen));
   // Free-running 10 MHz clock.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compares one register word and counts the outcome.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One Avalon transfer; the request is held until waitrequest is seen low.
   task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_i  <= w;
      rd_i  <= ~w;
      addr  <= a;
      wdata <= d;
      do @(posedge clk); while (wait_o !== 1'b0);
      rd = rdata;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask
   // Polls the flag word until the port flag rises, with a bounded count.
   task wirq();
      int n;
      n = 0;
      do begin
         bus(1'b0, 3'h4, 32'h0);
         n++;
      end while (rd[0] !== 1'b1 && n < 500);
      // An exhausted poll limit counts as a failure.
      if (rd[0] !== 1'b1) begin
         miscompares++;
         $display("MISMATCH %0t port flag never rose", $time);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Watchdog: the whole sequence needs far fewer than 30000 cycles.
   initial begin
      #3000000;
      miscompares++;
      conclude();
   end
   // Main sequence.
   initial begin
      {arst_n, rd_i, wr_i, stretch, jam, addr, wdata} = '0;
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      // Reset values, unmapped index included.
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, row_a[i], 32'h0);
         chk(rd, row_e[i]);
      end
      bus(1'b1, 3'h2, 32'h3);
      bus(1'b1, 3'h0, 32'h1);
      bus(1'b1, 3'h3, 32'h55);
      bus(1'b1, 3'h0, 32'h4);
      wirq();
      chk(rd, 32'h5);
      bus(1'b0, 3'h0, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 3'h1, 32'h0);
      chk(rd & 32'h8, 32'h8);
      chk({31'h0, sda_oe_n}, 32'h0);
      bus(1'b1, 3'h4, 32'h7);
      bus(1'b1, 3'h3, 32'hA0);
      wirq();
      chk({23'h0, seen}, 32'h141);
      chk({31'h0, scl_oe_n}, 32'h0);
      bus(1'b0, 3'h0, 32'h0);
      chk(rd, 32'h40);
      bus(1'b1, 3'h4, 32'h7);
      bus(1'b1, 3'h0, 32'h2);
      wirq();
      bus(1'b0, 3'h0, 32'h0);
      chk(rd & 32'h2, 32'h0);
      chk({31'h0, sda_oe_n}, 32'h0);
      bus(1'b1, 3'h4, 32'h7);
      // Read address after the restart; a restart request mid-byte must be dropped.
      bus(1'b1, 3'h3, 32'hA1);
      bus(1'b1, 3'h0, 32'h2);
      wirq();
      chk({23'h0, seen}, 32'h143);
      bus(1'b0, 3'h0, 32'h0);
      chk(rd, 32'h40);
      bus(1'b1, 3'h4, 32'h7);
      // Receive one byte from the idle-high line, answering with a released ack.
      bus(1'b1, 3'h0, 32'h28);
      wirq();
      chk({23'h0, seen}, 32'h1FF);
      bus(1'b0, 3'h3, 32'h0);
      chk(rd, 32'hFF);
      bus(1'b1, 3'h4, 32'h7);
      // A stretched STOP must still finish once SCL is let go.
      bus(1'b1, 3'h0, 32'h4);
      stretch <= 1'b1;
      repeat (40) @(posedge clk);
      stretch <= 1'b0;
      wirq();
      bus(1'b0, 3'h1, 32'h0);
      chk(rd & 32'h10, 32'h10);
      chk({31'h0, sda_oe_n}, 32'h1);
      bus(1'b1, 3'h4, 32'h7);
      jam <= 1'b1;
      bus(1'b1, 3'h0, 32'h1);
      repeat (20) @(posedge clk);
      bus(1'b0, 3'h4, 32'h0);
      chk(rd & 32'h2, 32'h2);
      bus(1'b0, 3'h0, 32'h0);
      chk(rd & 32'h1, 32'h0);
      conclude();
   end
endmodule

// >>> verilog/i2c_master_start_restart_brg.sv
// I2C master sequencer with START, Repeated START, STOP, byte engine and rate counter.
`timescale 1ns/100ps
// Operation
// [R01] Master makes all SCL, START and STOP.
// [R02] Write: address with direction 0, ack in.
// [R03] Read: address with direction 1, ack out.
// [R04] Software sets start, waits for interrupt.
// [R05] Ack sampled to bit 6, flag after ninth.
// [R06] Stop request makes STOP, then flag.
// [R07] Divider low seven bits; buffer write starts.
// [R08] Counter counts to zero and halts.
// [R09] Counter stops after operation; SCL holds.
// [R10] SCL period is two rollovers.
// [R11] Released SCL waits high before counting.
// [R12] Start: both high, timeout, SDA low.
// [R13] Second timeout clears start, SDA held.
// [R14] Start collision sets flag, returns idle.
// [R15] Buffer write during START is discarded.
// [R16] Control low bits blocked while busy.
// [R17] Restart pulls SCL low, loads bits 5:0.
// [R18] Restart releases, then SDA low, clears.
// [R19] Start seen early; interrupt after timeout.
// [R20] Restart during other event is ignored.
// [R21] Restart collision on SDA or SCL low.
// [R22] Software sends address after restart flag.
// [R23] Software clears write collision flag.
// [R24] Restart collision flags, clears, idles.
// [R25] Lines synchronised; actions on counter ticks.
module i2c_master_start_restart_brg (
   input  wire logic        clk_sys_i,
   input  wire logic        arst_n_i,
   input  wire logic [2:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe_n_o,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o
);

   // Sequencer states.
   typedef enum logic [4:0] {
      IDLE, ST_WAIT, ST_HOLD,
      RS_LOW, RS_SDA, RS_REL, RS_HIGH, RS_SDAL,
      BIT_LOW, BIT_REL, BIT_HIGH,
      SP_LOW, SP_A, SP_REL, SP_B, SP_SDA, SP_C
   } state_t;

   state_t                  state_q, state_d;       // Sequencer state.
   logic                    wait_q;                  // Registered waitrequest.
   logic [31:0]             rdata_q;                 // Registered read data.
   logic                    scl_rel_q, scl_rel_d;    // 1 = SCL released.
   logic                    sda_rel_q, sda_rel_d;    // 1 = SDA released.
   logic                    start_q, start_d;        // Start request bit.
   logic                    rstrt_q, rstrt_d;        // Restart request bit.
   logic                    stop_q, stop_d;          // Stop request bit.
   logic                    rxen_q, rxen_d;          // Receive enable bit.
   logic                    ackd_q, ackd_d;          // Ack level sent after a read byte.
   logic                    acks_q, acks_d;          // Ack level seen after a written byte.
   logic                    sseen_q, sseen_d;        // START seen on the bus.
   logic                    pseen_q, pseen_d;        // STOP seen on the bus.
   logic [6:0]              div_q, div_d;            // Divider register.
   logic [7:0]              buf_q, buf_d;            // Shift buffer.
   logic                    full_q, full_d;          // Buffer full.
   logic [7:0]              shift_q, shift_d;        // Shift register.
   logic [3:0]              bit_q, bit_d;            // Bit slot 0..8 of a byte.
   logic                    rxm_q, rxm_d;            // Current byte is a receive.
   i2c_master_pkg::flags_t  flags_q, flags_d;        // Sticky event flags.
   i2c_master_pkg::flags_t  fset;                    // Events of this cycle.
   logic                    sda_prev_q;              // Last synchronised SDA.
   logic                    cnt_load, cnt_stop;      // Counter controls.
   logic [6:0]              cnt_val;                 // Counter reload value.
   logic                    expire, cnt_busy;        // Counter status.
   logic                    scl_s, sda_s;            // Synchronised lines.

   // Bus access decode; a request is taken on the edge where waitrequest is low.
   wire acc_go   = (read_i || write_i) && wait_q;
   wire wr_en    = write_i && !wait_q;
   wire rd_en    = read_i && !wait_q;
   wire wr_ctrl  = wr_en && (address_i == i2c_master_pkg::IDX_CTRL);
   wire wr_div   = wr_en && (address_i == i2c_master_pkg::IDX_DIV);
   wire wr_buf   = wr_en && (address_i == i2c_master_pkg::IDX_BUF);
   wire wr_flags = wr_en && (address_i == i2c_master_pkg::IDX_FLAGS);
   wire rd_buf   = rd_en && (address_i == i2c_master_pkg::IDX_BUF);
   wire idle     = (state_q == IDLE);
   wire buf_ok   = idle && !start_q && !rstrt_q && !stop_q && !rxen_q;
   wire start_det = sda_prev_q && !sda_s && scl_s;
   wire stop_det  = !sda_prev_q && sda_s && scl_s;

   // Read data selection; unmapped indices read as zero.
   wire [31:0] ctrl_rd = {25'h0, acks_q, ackd_q, 1'b0, rxen_q, stop_q, rstrt_q, start_q};
   wire [31:0] stat_rd = {27'h0, pseen_q, sseen_q, 2'h0, full_q};
   wire [31:0] rd_mux =
      (address_i == i2c_master_pkg::IDX_CTRL)   ? ctrl_rd :
      (address_i == i2c_master_pkg::IDX_STATUS) ? stat_rd :
      (address_i == i2c_master_pkg::IDX_DIV)    ? {25'h0, div_q} :
      (address_i == i2c_master_pkg::IDX_BUF)    ? {24'h0, buf_q} :
      (address_i == i2c_master_pkg::IDX_FLAGS)  ? {29'h0, flags_q} : 32'h0000_0000;

   // Open-drain pins only ever pull low; the enables carry the level.
   assign scl_o         = 1'b0;
   assign sda_o         = 1'b0;
   assign scl_oe_n_o    = scl_rel_q;
   assign sda_oe_n_o    = sda_rel_q;
   assign waitrequest_o = wait_q;
   assign readdata_o    = rdata_q;

   // [R25] line synchronisers
   line_sync u_scl_sync (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .line_i    (scl_i),
      .line_o    (scl_s)
   );
   line_sync u_sda_sync (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .line_i    (sda_i),
      .line_o    (sda_s)
   );

   // Rate counter paces every phase; rollover length is reload plus one tick.
   rate_counter u_rate (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .load_i    (cnt_load),
      .stop_i    (cnt_stop),
      .reload_i  (cnt_val),
      .expire_o  (expire),
      .busy_o    (cnt_busy)
   );

   // Software writes, bus condition detection, then the sequencer itself.
   always_comb begin
      state_d = state_q;   scl_rel_d = scl_rel_q; sda_rel_d = sda_rel_q;
      start_d = start_q;   rstrt_d = rstrt_q;     stop_d = stop_q;
      rxen_d  = rxen_q;    ackd_d = ackd_q;       acks_d = acks_q;
      sseen_d = sseen_q;   pseen_d = pseen_q;     div_d = div_q;
      buf_d   = buf_q;     full_d = full_q;       shift_d = shift_q;
      bit_d   = bit_q;     rxm_d = rxm_q;         fset = '0;
      cnt_load = 1'b0;     cnt_stop = 1'b0;
      cnt_val  = div_q;    // [R07] reload from divider
      // [R16] block queued events
      if (wr_ctrl) begin
         ackd_d = writedata_i[i2c_master_pkg::CTRL_ACKDATA_BIT];
         // [R20] restart only when idle
         if (idle) begin
            start_d = writedata_i[i2c_master_pkg::CTRL_START_BIT];
            rstrt_d = writedata_i[i2c_master_pkg::CTRL_RESTART_BIT];
            stop_d  = writedata_i[i2c_master_pkg::CTRL_STOP_BIT];
            rxen_d  = writedata_i[i2c_master_pkg::CTRL_RXEN_BIT];
         end
      end
      if (wr_div) begin
         div_d = writedata_i[6:0];
      end
      // [R15] discard busy buffer write
      if (wr_buf && !buf_ok) begin
         fset.write_collision_flag = 1'b1;
      end
      if (rd_buf && rxm_q) begin
         full_d = 1'b0;
      end
      // [R19] start seen on lines
      if (start_det) begin
         sseen_d = 1'b1;
         pseen_d = 1'b0;
      end else if (stop_det) begin
         pseen_d = 1'b1;
         sseen_d = 1'b0;
      end
      // [R01] master sequencer
      unique case (state_q)
         IDLE: begin
            // [R12] start needs both lines high
            if (start_q) begin
               if (scl_s && sda_s) begin
                  cnt_load = 1'b1;
                  state_d  = ST_WAIT;
               end else begin
                  // [R14] start collision at entry
                  fset.coll = 1'b1;
                  start_d   = 1'b0;
               end
            end else if (rstrt_q) begin
               // [R17] restart pulls SCL low
               scl_rel_d = 1'b0;
               state_d   = RS_LOW;
            end else if (stop_q) begin
               // [R06] STOP begins with SDA low
               sda_rel_d = 1'b0;
               state_d   = SP_LOW;
            end else if (rxen_q) begin
               // [R03] receive a byte, SDA released
               shift_d = 8'h00;
               bit_d = 4'h0;
               rxm_d = 1'b1;
               // SCL falls on the same clock edge that releases SDA, so both lines move together.
               scl_rel_d = 1'b0;
               sda_rel_d = 1'b1;
               cnt_load = 1'b1;
               state_d = BIT_LOW;
            end else if (wr_buf) begin
               // [R07] buffer write starts counter
               buf_d = writedata_i[7:0];
               shift_d = writedata_i[7:0];
               full_d = 1'b1;
               bit_d = 4'h0;
               rxm_d = 1'b0;
               // Pulling SCL low here keeps the first data bit from looking like a STOP.
               scl_rel_d = 1'b0;
               sda_rel_d = writedata_i[7];
               cnt_load = 1'b1;
               state_d = BIT_LOW;
            end
         end
         ST_WAIT: begin
            if (!scl_s || (expire && !sda_s)) begin
               // [R14] SCL fell before SDA driven
               fset.coll = 1'b1;
               start_d = 1'b0;
               cnt_stop = 1'b1;
               state_d = IDLE;
            end else if (expire) begin
               // [R12] drive SDA low at timeout
               sda_rel_d = 1'b0;
               cnt_load = 1'b1;
               state_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (expire) begin
               // [R13] hardware clears start, SDA held
               // [R04] interrupt tells software to load address
               start_d = 1'b0;
               fset.pirq = 1'b1;
               state_d = IDLE;
            end
         end
         RS_LOW: begin
            if (!scl_s) begin
               // [R17] load bits 5:0, release SDA
               cnt_val = {1'b0, div_q[5:0]};
               cnt_load = 1'b1;
               sda_rel_d = 1'b1;
               state_d = RS_SDA;
            end
         end
         RS_SDA: begin
            if (expire) begin
               if (sda_s) begin
                  // [R18] release SCL when SDA high
                  scl_rel_d = 1'b1;
                  state_d = RS_REL;
               end else begin
                  // [R24] abandon restart
                  fset.coll = 1'b1;
                  rstrt_d = 1'b0;
                  scl_rel_d = 1'b1;
                  state_d = IDLE;
               end
            end
         end
         RS_REL: begin
            // [R11] wait for SCL really high
            if (scl_s) begin
               if (!sda_s) begin
                  // [R21] SDA low as SCL rises
                  fset.coll = 1'b1;
                  rstrt_d = 1'b0;
                  state_d = IDLE;
               end else begin
                  cnt_load = 1'b1;
                  state_d = RS_HIGH;
               end
            end
         end
         RS_HIGH: begin
            if (!scl_s || !sda_s) begin
               // [R21] SCL fell before SDA asserted
               // [R24] flag, clear and idle
               fset.coll = 1'b1;
               rstrt_d = 1'b0;
               cnt_stop = 1'b1;
               state_d = IDLE;
            end else if (expire) begin
               // [R18] SDA low for one period
               sda_rel_d = 1'b0;
               cnt_load = 1'b1;
               state_d = RS_SDAL;
            end
         end
         RS_SDAL: begin
            if (expire) begin
               // [R19] interrupt only after timeout
               rstrt_d = 1'b0;
               fset.pirq = 1'b1;
               state_d = IDLE;
            end
         end
         BIT_LOW: begin
            if (expire) begin
               scl_rel_d = 1'b1;
               state_d = BIT_REL;
            end
         end
         BIT_REL: begin
            // [R11] pause until SCL high
            if (scl_s) begin
               cnt_load = 1'b1;
               state_d = BIT_HIGH;
            end
         end
         BIT_HIGH: begin
            if (expire) begin
               // [R10] second rollover ends the SCL period
               scl_rel_d = 1'b0;
               if (bit_q == i2c_master_pkg::LAST_BIT) begin
                  // [R05] ack sampled, flag after ninth
                  // [R09] counter left stopped, SCL low
                  if (!rxm_q) begin
                     acks_d = sda_s;
                     full_d = 1'b0;
                  end else begin
                     buf_d = shift_q;
                     full_d = 1'b1;
                     rxen_d = 1'b0;
                  end
                  sda_rel_d = 1'b1;
                  fset.pirq = 1'b1;
                  state_d = IDLE;
               end else begin
                  // [R02] shift out eight bits then release
                  // [R03] shift in eight bits then ack
                  shift_d = rxm_q ? {shift_q[6:0], sda_s} : {shift_q[6:0], 1'b0};
                  bit_d = bit_q + 4'h1;
                  if (bit_q == 4'h7) begin
                     sda_rel_d = rxm_q ? ackd_q : 1'b1;
                  end else begin
                     sda_rel_d = rxm_q ? 1'b1 : shift_q[6];
                  end
                  cnt_load = 1'b1;
                  state_d = BIT_LOW;
               end
            end
         end
         SP_LOW: begin
            if (!sda_s) begin
               cnt_load = 1'b1;
               state_d = SP_A;
            end
         end
         SP_A: begin
            if (expire) begin
               scl_rel_d = 1'b1;
               state_d = SP_REL;
            end
         end
         SP_REL: begin
            if (scl_s) begin
               cnt_load = 1'b1;
               state_d = SP_B;
            end
         end
         SP_B: begin
            if (expire) begin
               sda_rel_d = 1'b1;
               state_d = SP_SDA;
            end
         end
         SP_SDA: begin
            if (sda_s && scl_s) begin
               cnt_load = 1'b1;
               state_d = SP_C;
            end
         end
         SP_C: begin
            if (expire) begin
               // [R06] interrupt once STOP complete
               stop_d = 1'b0;
               fset.pirq = 1'b1;
               state_d = IDLE;
            end
         end
         default: begin
            state_d = IDLE;
         end
      endcase
      // [R23] software clears flags, events win
      flags_d = (flags_q & ~(wr_flags ? writedata_i[2:0] : 3'h0)) | fset;
   end

   // Bus answer: waitrequest drops for exactly one cycle per request.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q  <= !acc_go;
         rdata_q <= acc_go ? rd_mux : rdata_q;
      end
   end

   // Sequencer and register state.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= IDLE;   scl_rel_q <= 1'b1;  sda_rel_q <= 1'b1;
         start_q <= 1'b0;   rstrt_q <= 1'b0;    stop_q <= 1'b0;
         rxen_q  <= 1'b0;   ackd_q <= 1'b0;     acks_q <= 1'b0;
         sseen_q <= 1'b0;   pseen_q <= 1'b0;    div_q <= i2c_master_pkg::DIV_RST;
         buf_q   <= i2c_master_pkg::BUF_RST;    full_q <= 1'b0;
         shift_q <= 8'h00;  bit_q <= 4'h0;      rxm_q <= 1'b0;
         flags_q <= i2c_master_pkg::FLAGS_RST;  sda_prev_q <= 1'b1;
      end else begin
         state_q <= state_d; scl_rel_q <= scl_rel_d; sda_rel_q <= sda_rel_d;
         start_q <= start_d; rstrt_q <= rstrt_d;     stop_q <= stop_d;
         rxen_q  <= rxen_d;  ackd_q <= ackd_d;       acks_q <= acks_d;
         sseen_q <= sseen_d; pseen_q <= pseen_d;     div_q <= div_d;
         buf_q   <= buf_d;   full_q <= full_d;       shift_q <= shift_d;
         bit_q   <= bit_d;   rxm_q <= rxm_d;         flags_q <= flags_d;
         sda_prev_q <= sda_s;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   a_start_sda_low: assert property ( // [R12]
      state_q == ST_WAIT && expire && scl_s && sda_s |=> !sda_rel_q && state_q == ST_HOLD)
      else $error("START did not drive SDA low at timeout");
   a_start_clear: assert property ( // [R13]
      state_q == ST_HOLD && expire |=> !start_q && !sda_rel_q && flags_q.pirq)
      else $error("START completion wrong");
   a_start_coll: assert property ( // [R14]
      idle && start_q && !(scl_s && sda_s) |=> flags_q.coll && idle && !start_q)
      else $error("START collision not flagged");
   a_write_collision_flag_discard: assert property ( // [R15]
      wr_buf && !buf_ok |=> flags_q.write_collision_flag && buf_q == $past(buf_q))
      else $error("busy buffer write not discarded");
   a_ctrl_blocked: assert property ( // [R16]
      wr_ctrl && state_q == ST_HOLD |=> stop_q == $past(stop_q) && rxen_q == $past(rxen_q))
      else $error("control write took effect while busy");
   a_restart_scl: assert property ( // [R17]
      idle && rstrt_q && !start_q |=> !scl_rel_q && state_q == RS_LOW)
      else $error("restart did not pull SCL low");
   a_restart_done: assert property ( // [R18]
      state_q == RS_SDAL && expire |=> !rstrt_q && !sda_rel_q && flags_q.pirq)
      else $error("restart completion wrong");
   a_ack_sample: assert property ( // [R05]
      state_q == BIT_HIGH && expire && bit_q == 4'h8 && !rxm_q
      |=> acks_q == $past(sda_s) && flags_q.pirq && idle)
      else $error("ack not sampled after ninth clock");
   a_scl_wait: assert property ( // [R11]
      state_q == BIT_REL && !scl_s |=> !cnt_busy && state_q == BIT_REL)
      else $error("counter ran while SCL held low");
   a_rate_timeout: assert property ( // [R10]
      cnt_load && !cnt_stop |-> ##[1:129] expire)
      else $error("rollover longer than reload allows");
   a_restart_ignore: assert property ( // [R20]
      wr_ctrl && state_q == BIT_LOW |=> !rstrt_q)
      else $error("restart accepted while busy");

   c_start_done: cover property (state_q == ST_HOLD && expire);
   c_restart_done: cover property (state_q == RS_SDAL && expire);
   c_byte_done: cover property (state_q == BIT_HIGH && expire && bit_q == 4'h8);
   c_collision: cover property (fset.coll);

endmodule

// >>> verilog/line_sync.sv
// Two-flop synchroniser for one bus line.
`timescale 1ns/100ps
module line_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic clk_sys_i,
   input  wire logic arst_n_i,
   input  wire logic line_i,
   output logic      line_o
);

   logic meta_q; // First stage, read only by the second stage.

   // Idle bus lines are high, so both stages reset to the released level.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= RST_VAL;
         line_o <= RST_VAL;
      end else begin
         meta_q <= line_i;
         line_o <= meta_q;
      end
   end

endmodule

// >>> verilog/rate_counter.sv
// Reloadable down counter that paces every SCL and SDA phase.
`timescale 1ns/100ps
module rate_counter (
   input  wire logic       clk_sys_i,
   input  wire logic       arst_n_i,
   input  wire logic       load_i,
   input  wire logic       stop_i,
   input  wire logic [6:0] reload_i,
   output logic            expire_o,
   output logic            busy_o
);

   logic [6:0] cnt_q; // Remaining ticks of the current rollover.
   logic       run_q; // High while counting down.

   // Each clock edge stands for one counter tick phase.
   assign expire_o = run_q && (cnt_q == 7'h00);
   assign busy_o   = run_q;

   // Count down to zero and halt there until the next load.
   // [R08] halt at zero
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_q <= 7'h00;
         run_q <= 1'b0;
      end else if (load_i) begin
         cnt_q <= reload_i;
         run_q <= 1'b1;
      end else if (stop_i || expire_o) begin
         run_q <= 1'b0;
      end else if (run_q) begin
         cnt_q <= cnt_q - 7'h01;
      end
   end

endmodule
